// [hdl/timer_mode_regs.vh]
// Register indices, field positions, codes and reset values of the timer
`ifndef TIMER_MODE_REGS_VH
`define TIMER_MODE_REGS_VH

// ======================================================================
// Register indices (byte address is four times the index)
`define MODE_IDX_CH0    24'h0f0190
`define MODE_IDX_STEP   24'h000002
`define MODE_IDX_PAGE   20'h0f019
`define CMP_IDX_CH0     24'h0f0180
`define CMP_IDX_PAGE    20'h0f018
`define STAT_IDX        24'h0f01b0
`define MASK_IDX        24'h0f01b2
`define CTRL_IDX        24'h0f01b4
`define VEC_IDX         24'h0f01b6

// ======================================================================
// Mode register fields
`define MODE_RST        16'h0000
`define MODE_WMASK      16'hd7cf
`define MODE_B11_MASK   16'h0800
`define ROLE_BIT        11
`define TRIG_HI         10
`define TRIG_LO         8
`define EDGE_HI         7
`define EDGE_LO         6

// ======================================================================
// Trigger source codes
`define TRIG_SW         3'h0
`define TRIG_EDGE       3'h1
`define TRIG_BOTH       3'h2
`define TRIG_MASTER     3'h4

// Input edge select codes
`define EDGE_FALL       2'h0
`define EDGE_RISE       2'h1

// ======================================================================
// Interrupt vectors and default priorities of channels 5, 6, 7
`define VEC_CH5         16'h0044
`define VEC_CH6         16'h0046
`define VEC_CH7         16'h0048
`define PRIO_CH5        6'h1d
`define PRIO_CH6        6'h1e
`define PRIO_CH7        6'h1f

// Reset values of the other registers
`define CMP_RST         16'h0000
`define IRQ_RST         3'h0

`endif

// [hdl/timer_channel_mode_control.v]
// Eight-channel timer array with per-channel mode control on Wishbone
`timescale 1ns/1ns
`include "timer_mode_regs.vh"

// Behaviour
// [RQ1] Eight channels 0 to 7 in unit 0, each with its own mode register.
// [RQ2] Only channels 0, 4 and 7 connect to an input pin and an output pin.
// [RQ3] On channels 2, 4, 6 bit 11 set makes the channel a master.
// [RQ4] No channel other than 2, 4 or 6 can be made a master by software.
// [RQ5] Channel 0 is always a master whatever its bits say.
// [RQ6] Software keeps bit 11 clear on 2, 4, 6 when used independently.
// [RQ7] On channels 1 and 3 bit 11 set splits the counter to 8 bits.
// [RQ8] On channels 0, 5, 7 bit 11 reads 0 and writes to it are ignored.
// [RQ9] Trigger code 000 starts only by software; pin and master ignored.
// [RQ10] Code 001 uses the selected pin edge as start and capture trigger.
// [RQ11] Code 010 uses both pin edges as start and capture trigger.
// [RQ12] Code 100 makes a slave follow its master's interrupt; other codes
//        are not to be written by software.
// [RQ13] Channels 5, 6, 7 raise maskable interrupts at vectors 44h-48h.
// [RQ14] Those interrupts carry default priorities 29, 30 and 31.
// [RQ15] Of several pending interrupts the lowest priority number wins.
// [RQ16] Bit 13 and bits 5 to 4 of each mode register read as 0.
// [RQ17] Every mode register clears to zero on reset.
module timer_channel_mode_control (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [25:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  // Timer pins of channels 0, 4, 7
  input  wire [2:0]  chan_in_i,
  output wire [2:0]  chan_out_o,
  // Interrupts
  output wire        chan5_done_irq_o,
  output wire        chan6_done_irq_o,
  output wire        chan7_done_irq_o,
  output wire        irq_o
);

  // ======================================================================
  // Helper functions
  function has_role_bit;
    input [2:0] n;
    begin
      has_role_bit = (n == 3'd1) || (n == 3'd2) || (n == 3'd3) ||
                     (n == 3'd4) || (n == 3'd6);
    end
  endfunction

  // Bits 13, 5, 4 never stored; bit 11 only where it exists
  function [15:0] mode_wmask;
    input [2:0] n;
    begin
      mode_wmask = `MODE_WMASK;                                   // [RQ16]
      if (has_role_bit(n)) begin
        mode_wmask = `MODE_WMASK | `MODE_B11_MASK;                // [RQ8]
      end
    end
  endfunction

  function is_master;
    input [2:0]  n;
    input [15:0] mode;
    begin
      if (n == 3'd0) begin
        is_master = 1'b1;                                         // [RQ5]
      end else if (n == 3'd2 || n == 3'd4 || n == 3'd6) begin
        is_master = mode[`ROLE_BIT];                          // [RQ3] [RQ4]
      end else begin
        is_master = 1'b0;
      end
    end
  endfunction

  function is_split;
    input [2:0]  n;
    input [15:0] mode;
    begin
      is_split = ((n == 3'd1) || (n == 3'd3)) & mode[`ROLE_BIT];  // [RQ7]
    end
  endfunction

  // Split channels only look at the low byte of the count
  function cnt_at_end;
    input [2:0]  n;
    input [15:0] mode;
    input [15:0] cnt;
    begin
      if (is_split(n, mode)) begin
        cnt_at_end = (cnt[7:0] == 8'h00);
      end else begin
        cnt_at_end = (cnt == 16'h0000);
      end
    end
  endfunction

  // Pin index of a channel, 3 when it has none
  function [1:0] pin_of;
    input [2:0] n;
    begin
      if (n == 3'd0) begin
        pin_of = 2'd0;                                            // [RQ2]
      end else if (n == 3'd4) begin
        pin_of = 2'd1;
      end else if (n == 3'd7) begin
        pin_of = 2'd2;
      end else begin
        pin_of = 2'd3;
      end
    end
  endfunction

  // ======================================================================
  // State
  reg [15:0] mode_ff [0:7];                                       // [RQ1]
  reg [15:0] cmp_ff  [0:7];
  reg [15:0] cnt_ff  [0:7];
  reg [7:0]  run_ff;
  reg [7:0]  done_ff;
  reg [2:0]  pin_q_ff;
  reg [2:0]  tout_ff;
  reg [2:0]  stat_ff;
  reg [2:0]  mask_ff;
  reg        irq_ff;
  reg        ack_ff;
  reg [31:0] rdat_ff;

  // ======================================================================
  // Bus decode
  wire [23:0] idx    = wb_adr_i[25:2];
  wire        req    = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire        wr     = req & wb_we_i;
  wire [2:0]  sel_ch = idx[3:1];
  wire        hit_mode = (idx[23:4] == `MODE_IDX_PAGE) & ~idx[0];
  wire        hit_cmp  = (idx[23:4] == `CMP_IDX_PAGE) & ~idx[0];
  wire [15:0] lane_m = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // ======================================================================
  // Trigger generation
  reg [7:0]  hw_trig;
  reg [7:0]  cap_ok;
  reg        mst_carry;
  reg        p_now;
  reg        p_old;
  reg        rise;
  reg        fall;
  reg [2:0]  code;
  reg [1:0]  pidx;
  integer    k;

  always @* begin
    hw_trig   = 8'h00;
    cap_ok    = 8'h00;
    mst_carry = 1'b0;
    p_now     = 1'b0;
    p_old     = 1'b0;
    rise      = 1'b0;
    fall      = 1'b0;
    code      = 3'h0;
    pidx      = 2'd3;
    for (k = 0; k < 8; k = k + 1) begin
      code = mode_ff[k][`TRIG_HI:`TRIG_LO];
      pidx = pin_of(k[2:0]);
      if (pidx != 2'd3) begin
        p_now = chan_in_i[pidx];
        p_old = pin_q_ff[pidx];
      end else begin
        p_now = 1'b0;
        p_old = 1'b0;
      end
      rise = p_now & ~p_old;
      fall = ~p_now & p_old;
      if (code == `TRIG_EDGE) begin
        cap_ok[k] = 1'b1;
        if (mode_ff[k][`EDGE_HI:`EDGE_LO] == `EDGE_FALL) begin
          hw_trig[k] = fall;                                      // [RQ10]
        end else if (mode_ff[k][`EDGE_HI:`EDGE_LO] == `EDGE_RISE) begin
          hw_trig[k] = rise;
        end else begin
          hw_trig[k] = rise | fall;
        end
      end else if (code == `TRIG_BOTH) begin
        cap_ok[k]  = 1'b1;
        hw_trig[k] = rise | fall;                                 // [RQ11]
      end else if (code == `TRIG_MASTER) begin
        hw_trig[k] = mst_carry;                                   // [RQ12]
      end else begin
        hw_trig[k] = 1'b0;                                        // [RQ9]
      end
      // A master hands its event to the slaves above it, up to the next master
      if (is_master(k[2:0], mode_ff[k])) begin
        mst_carry = done_ff[k];
      end
    end
  end

  // ======================================================================
  // Interrupt status, priority and vector
  wire [2:0] nxt_stat;
  wire [2:0] clr = (wr & (idx == `STAT_IDX) & wb_sel_i[0]) ?
                   wb_dat_i[2:0] : 3'h0;
  // Set beats clear so an event in the clearing cycle survives
  assign nxt_stat = (stat_ff & ~clr) | done_ff[7:5];              // [RQ13]
  wire [2:0] pend = stat_ff & mask_ff;

  reg [21:0] vec_sel;
  always @* begin
    if (pend[0]) begin
      vec_sel = {`PRIO_CH5, `VEC_CH5};                      // [RQ14] [RQ15]
    end else if (pend[1]) begin
      vec_sel = {`PRIO_CH6, `VEC_CH6};
    end else if (pend[2]) begin
      vec_sel = {`PRIO_CH7, `VEC_CH7};
    end else begin
      vec_sel = 22'h000000;
    end
  end

  // ======================================================================
  // Read mux
  reg [31:0] rd_mux;
  always @* begin
    if (hit_mode) begin
      rd_mux = {16'h0000, mode_ff[sel_ch] & mode_wmask(sel_ch)};  // [RQ8]
    end else if (hit_cmp) begin
      rd_mux = {16'h0000, cmp_ff[sel_ch]};
    end else if (idx == `STAT_IDX) begin
      rd_mux = {29'h00000000, stat_ff};
    end else if (idx == `MASK_IDX) begin
      rd_mux = {29'h00000000, mask_ff};
    end else if (idx == `CTRL_IDX) begin
      rd_mux = {24'h000000, run_ff};
    end else if (idx == `VEC_IDX) begin
      rd_mux = {10'h000, vec_sel};
    end else begin
      rd_mux = 32'h00000000;
    end
  end

  // ======================================================================
  // Channels and registers
  wire        ctrl_wr = wr & (idx == `CTRL_IDX);
  wire [7:0]  sw_go   = (ctrl_wr & wb_sel_i[0]) ? wb_dat_i[7:0] : 8'h00;
  wire [7:0]  sw_halt = (ctrl_wr & wb_sel_i[1]) ? wb_dat_i[15:8] : 8'h00;
  integer     c;

  always @(posedge clk_i) begin
    if (rst_i) begin
      for (c = 0; c < 8; c = c + 1) begin
        mode_ff[c] <= `MODE_RST;                                  // [RQ17]
        cmp_ff[c]  <= `CMP_RST;
        cnt_ff[c]  <= `CMP_RST;
      end
      run_ff   <= 8'h00;
      done_ff  <= 8'h00;
      pin_q_ff <= 3'h0;
      tout_ff  <= 3'h0;
      stat_ff  <= `IRQ_RST;
      mask_ff  <= `IRQ_RST;
      irq_ff   <= 1'b0;
      ack_ff   <= 1'b0;
      rdat_ff  <= 32'h00000000;
    end else begin
      ack_ff   <= req;
      rdat_ff  <= req ? rd_mux : 32'h00000000;
      pin_q_ff <= chan_in_i;
      stat_ff  <= nxt_stat;
      irq_ff   <= |(nxt_stat & mask_ff);
      if (wr & (idx == `MASK_IDX) & wb_sel_i[0]) begin
        mask_ff <= wb_dat_i[2:0];
      end
      if (wr & hit_mode) begin
        mode_ff[sel_ch] <= (mode_ff[sel_ch] & ~lane_m) |
                           (wb_dat_i[15:0] & lane_m & mode_wmask(sel_ch));
      end
      for (c = 0; c < 8; c = c + 1) begin
        done_ff[c] <= 1'b0;
        if (wr & hit_cmp & (sel_ch == c[2:0])) begin
          cmp_ff[c] <= (cmp_ff[c] & ~lane_m) | (wb_dat_i[15:0] & lane_m);
        end
        if (sw_halt[c]) begin
          run_ff[c] <= 1'b0;
        end else if (sw_go[c] | (hw_trig[c] & ~(run_ff[c] & cap_ok[c]))) begin
          run_ff[c] <= 1'b1;
          cnt_ff[c] <= cmp_ff[c];
        end else if (hw_trig[c] & run_ff[c] & cap_ok[c]) begin
          // Capture takes the running count and raises the event
          cmp_ff[c]  <= cnt_ff[c];
          done_ff[c] <= 1'b1;
        end else if (run_ff[c]) begin
          if (cnt_at_end(c[2:0], mode_ff[c], cnt_ff[c])) begin
            done_ff[c] <= 1'b1;
            if (is_split(c[2:0], mode_ff[c])) begin
              cnt_ff[c][7:0] <= cmp_ff[c][7:0];
            end else begin
              cnt_ff[c] <= cmp_ff[c];
            end
          end else if (is_split(c[2:0], mode_ff[c])) begin
            cnt_ff[c][7:0] <= cnt_ff[c][7:0] - 8'h01;
          end else begin
            cnt_ff[c] <= cnt_ff[c] - 16'h0001;
          end
        end
      end
      // Output pins toggle on each event of channels 0, 4, 7
      tout_ff <= tout_ff ^ {done_ff[7], done_ff[4], done_ff[0]};  // [RQ2]
    end
  end

  // ======================================================================
  // Outputs
  assign wb_ack_o         = ack_ff;
  assign wb_dat_o         = rdat_ff;
  assign chan_out_o       = tout_ff;
  assign chan5_done_irq_o = done_ff[5];                           // [RQ13]
  assign chan6_done_irq_o = done_ff[6];
  assign chan7_done_irq_o = done_ff[7];
  assign irq_o            = irq_ff;

endmodule

// [bench/tmc_sva.sv]
// Concurrent checks on the timer mode control block ports
`timescale 1ns/1ns
`include "timer_mode_regs.vh"
module tmc_sva (
  // Clock and reset
  input wire        clk_i,
  input wire        rst_i,
  // Bus
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [25:0] wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  // Events
  input wire        chan5_done_irq_o,
  input wire        irq_o
);
  logic [23:0] a_ff;
  logic        m_ff;
  wire         take;
  wire         md;
  wire         fixed;
  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign md = (a_ff >= `MODE_IDX_CH0) && (a_ff < `MODE_IDX_CH0 + 24'h10)
              && !a_ff[0];
  assign fixed = md && (a_ff[3:1] == 3'h0 || a_ff[3:1] == 3'h5
                        || a_ff[3:1] == 3'h7);
  // Shadow of the last address taken and of the channel 5 mask bit
  always @(posedge clk_i) begin
    if (rst_i) begin
      a_ff <= 24'h0;
      m_ff <= 1'b0;
    end else if (take) begin
      a_ff <= wb_adr_i[25:2];
      if (wb_we_i && wb_sel_i[0] && wb_adr_i[25:2] == `MASK_IDX)
        m_ff <= wb_dat_i[0];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ======================================================================
  // Properties
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_next: assert property (take |=> wb_ack_o)
    else $error("no ack in the cycle after a request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  a_mode_resv: assert property (wb_ack_o && md |->
    wb_dat_o[13] == 1'b0 && wb_dat_o[5:4] == 2'h0 && wb_dat_o[31:16] == 16'h0)
    else $error("reserved mode bits read nonzero");
  a_bit11_fixed: assert property (wb_ack_o && fixed |-> !wb_dat_o[11])
    else $error("fixed bit 11 reads one");
  a_vec_code: assert property (wb_ack_o && a_ff == `VEC_IDX |->
    wb_dat_o inside {32'h0, 32'h001d0044, 32'h001e0046, 32'h001f0048})
    else $error("bad vector and priority code");
  a_irq_path: assert property (chan5_done_irq_o && m_ff |=> irq_o)
    else $error("unmasked event did not raise the interrupt");
  a_done_pulse: assert property (chan5_done_irq_o |=> !chan5_done_irq_o)
    else $error("done pulse longer than one cycle");
  c_write: cover property (take && wb_we_i);
  c_irq: cover property ($rose(irq_o));
  c_vec: cover property (wb_ack_o && a_ff == `VEC_IDX && wb_dat_o != 32'h0);
endmodule
bind timer_channel_mode_control tmc_sva chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .chan5_done_irq_o(chan5_done_irq_o), .irq_o(irq_o));

// [bench/pin_partner.sv]
// Model of the timer input and output pins of channels 0, 4 and 7
`timescale 1ns/1ns
module pin_partner (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Pin requests and pins
  input  wire  [2:0] flip_i,
  input  wire  [2:0] pin_out_i,
  output logic [2:0] pin_in_o,
  output logic [7:0] out_edges_o
);
  logic [2:0] last_ff;
  // Only three pins exist, so every request maps to one of them
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_in_o <= 3'h0;
      last_ff <= 3'h0;
      out_edges_o <= 8'h0;
    end else begin
      pin_in_o <= pin_in_o ^ flip_i;
      last_ff <= pin_out_i;
      if (pin_out_i != last_ff)
        out_edges_o <= out_edges_o + 8'h01;
    end
  end
endmodule

// [bench/tb.sv]
// Self-checking bench of the timer mode control block
`timescale 1ns/1ns
`include "timer_mode_regs.vh"
module tb;
  logic        clk_i, rst_i, cyc, stb, we;
  logic [25:0] adr;
  logic [31:0] dat_w, q, o;
  logic [2:0]  flip;
  logic [7:0]  e0;
  wire  [31:0] dat_r;
  wire  [2:0]  pin_in, pin_out;
  wire  [7:0]  n_edges;
  wire         ack, d5, d6, d7, irq;
  int          n_mismatch, checks_done, cycles;
  logic [31:0] rows [9] = '{32'hffffd7cf, 32'hffffdfcf, 32'hffffdfcf,
    32'hffffdfcf, 32'hffffdfcf, 32'hffffd7cf, 32'hffffdfcf, 32'hffffd7cf,
    32'hffff0000};
  logic [31:0] vecs [3] = '{32'h001d0044, 32'h001e0046, 32'h001f0048};
  timer_channel_mode_control dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h3), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .chan_in_i(pin_in), .chan_out_o(pin_out), .chan5_done_irq_o(d5),
    .chan6_done_irq_o(d6), .chan7_done_irq_o(d7), .irq_o(irq));
  pin_partner pin_u (.clk_i(clk_i), .rst_i(rst_i), .flip_i(flip),
    .pin_out_i(pin_out), .pin_in_o(pin_in), .out_edges_o(n_edges));
  always #50 clk_i = ~clk_i;
  // ======================================================================
  // Bus and check tasks
  function automatic logic [25:0] ra(input logic [23:0] i);
    return {i, 2'b00};
  endfunction
  function automatic logic [25:0] ma(input logic [23:0] n);
    return ra(`MODE_IDX_CH0 + `MODE_IDX_STEP * n);
  endfunction
  function automatic logic [25:0] ca(input logic [23:0] n);
    return ra(`CMP_IDX_CH0 + 24'h2 * n);
  endfunction
  task automatic wb(input logic w, input logic [25:0] a,
                    input logic [15:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= {16'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [25:0] a, input logic [15:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rc(input logic [25:0] a, input logic [31:0] e);
    wb(1'b0, a, 16'h0);
    chk(q, e);
  endtask
  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      complete_run();
    end
  end
  // ======================================================================
  // Sequence
  initial begin
    {clk_i, rst_i, cyc, stb, we, adr, dat_w, flip} = {2'b01, 64'h0};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({28'h0, pin_out, irq}, 32'h0);
    for (int i = 0; i < 9; i++) begin
      o = {6'h0, ((i < 8) ? ma(i) : ra(24'h000040))};
      rc(o[25:0], 32'h0);
      wr(o[25:0], rows[i][31:16]);
      rc(o[25:0], {16'h0, rows[i][15:0]});
      wr(o[25:0], 16'h0);
    end
    // Three simultaneous events, then walk the mask down
    for (int i = 5; i < 8; i++) wr(ca(i), 16'h0002);
    wr(ra(`MASK_IDX), 16'h0007);
    wr(ra(`CTRL_IDX), 16'h00e0);
    for (int k = 0; k < 40 && d5 !== 1'b1; k++) @(posedge clk_i);
    chk({29'h0, d7, d6, d5}, 32'h7);
    wr(ra(`CTRL_IDX), 16'he000);
    for (int i = 0; i < 3; i++) begin
      wr(ra(`MASK_IDX), 16'h0007 << i & 16'h0007);
      rc(ra(`VEC_IDX), vecs[i]);
      chk({31'h0, irq}, 32'h1);
    end
    wr(ra(`MASK_IDX), 16'h0000);
    @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    rc(ra(`VEC_IDX), 32'h0);
    wr(ra(`STAT_IDX), 16'h0007);
    rc(ra(`STAT_IDX), 32'h0);
    // Pin triggers: rise on ch0, both edges on ch4, software only on ch7
    wr(ma(0), 16'h0140);
    wr(ma(4), 16'h0200);
    for (int i = 0; i < 8; i += 4) wr(ca(i), 16'h00ff);
    wr(ca(7), 16'h00ff);
    e0 = n_edges;
    for (int j = 0; j < 2; j++) begin
      o = {29'h0, pin_out};
      flip <= 3'h7;
      @(posedge clk_i);
      flip <= 3'h0;
      repeat (6) @(posedge clk_i);
    end
    chk({29'h0, pin_out}, o ^ 32'h2);
    chk({24'h0, n_edges}, {24'h0, e0 + 8'h01});
    rc(ra(`CTRL_IDX), 32'h0011);
    // Slave ch7 follows ch6 only while ch6 is master, else ch0
    wr(ra(`CTRL_IDX), 16'hff00);
    wr(ma(6), 16'h0800);
    wr(ma(7), 16'h0400);
    wr(ca(6), 16'h0003);
    wr(ca(0), 16'h0002);
    for (int j = 0; j < 2; j++) begin
      wr(ra(`CTRL_IDX), 16'h0040);
      for (int k = 0; k < 40 && d6 !== 1'b1; k++) @(posedge clk_i);
      chk({31'h0, d6}, 32'h1);
      repeat (3) @(posedge clk_i);
      rc(ra(`CTRL_IDX), j ? 32'h0040 : 32'h00c0);
      wr(ra(`CTRL_IDX), 16'hff00);
      wr(ma(6), 16'h0000);
    end
    wr(ra(`CTRL_IDX), 16'h0041);
    repeat (6) @(posedge clk_i);
    rc(ra(`CTRL_IDX), 32'h00c1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rc(ma(7), 32'h0);
    rc(ra(`CTRL_IDX), 32'h0);
    complete_run();
  end
endmodule
